// *** logic/rpd_regs.svh ***
// Register indices, field positions, defaults and timing for the power-up loader
`ifndef RPD_REGS_SVH
`define RPD_REGS_SVH

// Register indices; byte address is four times the index
`define RPD_IDX_ANALOG_CAL   6'h12
`define RPD_IDX_CTRL         6'h20
`define RPD_IDX_STATUS       6'h21

// Control register field positions
`define RPD_B_HALT           0
`define RPD_B_OSC_FAIL       1
`define RPD_B_TIMER_EN       2
`define RPD_B_TIMER_PULSE    3
`define RPD_B_TIMER_IRQ_EN   4
`define RPD_B_TIMER_DIV_LO   5
`define RPD_B_TIMER_DIV_HI   6
`define RPD_B_SQW_RATE0      7
`define RPD_B_SQW_UP_LSB     8
`define RPD_B_CAL_LOCK       11
`define RPD_B_ALM1_RPT_LSB   12
`define RPD_B_ALM2_RPT_LSB   17
`define RPD_B_ALM2_EN        22
`define RPD_CTRL_W           23

// First power-up value: halt, osc fail, both divider bits, rate bit0 set
`define RPD_CTRL_INIT        23'h0000E3

// Calibration load time and clock period
`define RPD_LOAD_TIME_NS     8000000
`define RPD_CLK_PERIOD_NS    25

`define RPD_RESP_OKAY        2'h0
`define RPD_RESP_SLVERR      2'h2

`endif

// *** logic/rpd_pkg.sv ***
// Types for the power-up defaults and calibration loader
package rpd_pkg;
    typedef enum logic [1:0] {
        RPD_SETTLE0,
        RPD_SETTLE1,
        RPD_INIT,
        RPD_RUN
    } rpd_state_t;
endpackage : rpd_pkg

// *** logic/rpd_loader.sv ***
// Power-up defaults, calibration lock and AXI4-Lite register slave
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "rpd_regs.svh"

// Functional notes
// - First power-up without battery presets halt, fail, divider, rate0; clears the rest.
// - Power-up with battery forces halt high, timer off, keeps other bits.
// - Lock set copies factory value into calibration register, which becomes read-only.
// - Lock clear makes calibration register an ordinary read/write register.
// - Calibration load takes about 8 ms after lock is set.
module rpd_loader #(
    parameter int LOAD_CYCLES = (`RPD_LOAD_TIME_NS + `RPD_CLK_PERIOD_NS - 1) / `RPD_CLK_PERIOD_NS
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        battery_retained,
    input  wire logic [7:0]  otp_cal_value,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             halt_update,
    output logic             osc_fail_flag,
    output logic             timer_enable,
    output logic             timer_irq_pulse_select,
    output logic             timer_irq_enable,
    output logic             timer_clk_div_hi,
    output logic             timer_clk_div_lo,
    output logic             sqw_rate_bit0,
    output logic [2:0]       sqw_rate_upper_bits,
    output logic [4:0]       alarm1_repeat_bits,
    output logic [4:0]       alarm2_repeat_bits,
    output logic             alarm2_enable,
    output logic             cal_lock,
    output logic [7:0]       analog_calibration,
    output logic             cal_busy
);

    rpd_pkg::rpd_state_t      state;
    rpd_pkg::rpd_state_t      next_state;
    // Battery-backed: no reset, loaded by the init step
    logic [`RPD_CTRL_W-1:0]   ctrl;
    logic [`RPD_CTRL_W-1:0]   next_ctrl;
    logic [7:0]               next_cal;
    logic [19:0]              load_cnt;
    logic [19:0]              next_load_cnt;
    logic                     next_busy;
    logic                     retained_seen;
    logic                     next_retained_seen;
    logic                     bat_q1;
    logic                     bat_q2;
    logic [7:0]               otp_q1;
    logic [7:0]               otp_q2;
    logic                     aw_full;
    logic                     next_aw_full;
    logic                     w_full;
    logic                     next_w_full;
    logic [5:0]               aw_idx;
    logic [5:0]               next_aw_idx;
    logic [31:0]              wdata;
    logic [31:0]              next_wdata;
    logic [3:0]               wstrb;
    logic [3:0]               next_wstrb;
    logic                     next_awready;
    logic                     next_wready;
    logic                     next_bvalid;
    logic [1:0]               next_bresp;
    logic                     next_arready;
    logic                     next_rvalid;
    logic [31:0]              next_rdata;
    logic [1:0]               next_rresp;
    logic                     wr_fire;

    function automatic logic idx_mapped(input logic [5:0] idx);
        idx_mapped = (idx == `RPD_IDX_ANALOG_CAL) || (idx == `RPD_IDX_CTRL)
                  || (idx == `RPD_IDX_STATUS);
    endfunction : idx_mapped

    function automatic logic [31:0] reg_read(input logic [5:0] idx);
        case (idx)
            `RPD_IDX_ANALOG_CAL: reg_read = {24'h000000, analog_calibration};
            `RPD_IDX_CTRL:       reg_read = {9'h000, ctrl};
            `RPD_IDX_STATUS:     reg_read = {30'h0, retained_seen, cal_busy};
            default:             reg_read = 32'h00000000;
        endcase
    endfunction : reg_read

    assign wr_fire = aw_full && w_full && !s_axi_bvalid;

    always_comb begin
        next_state         = state;
        next_ctrl          = ctrl;
        next_cal           = analog_calibration;
        next_load_cnt      = load_cnt;
        next_busy          = cal_busy;
        next_retained_seen = retained_seen;
        case (state)
            rpd_pkg::RPD_SETTLE0: next_state = rpd_pkg::RPD_SETTLE1;
            rpd_pkg::RPD_SETTLE1: next_state = rpd_pkg::RPD_INIT;
            rpd_pkg::RPD_INIT: begin
                next_state         = rpd_pkg::RPD_RUN;
                next_retained_seen = bat_q2;
                if (bat_q2) begin
                    next_ctrl[`RPD_B_HALT]     = 1'b1;
                    next_ctrl[`RPD_B_TIMER_EN] = 1'b0;
                    if (ctrl[`RPD_B_CAL_LOCK]) begin
                        next_load_cnt = LOAD_CYCLES[19:0];
                        next_busy     = 1'b1;
                    end
                end else begin
                    next_ctrl = `RPD_CTRL_INIT;
                    next_cal  = 8'h00;
                end
            end
            rpd_pkg::RPD_RUN: begin
                if (wr_fire && aw_idx == `RPD_IDX_CTRL) begin
                    if (wstrb[0]) next_ctrl[7:0] = wdata[7:0];
                    if (wstrb[1]) next_ctrl[15:8] = wdata[15:8];
                    if (wstrb[2]) next_ctrl[22:16] = wdata[22:16];
                end
                if (wr_fire && aw_idx == `RPD_IDX_ANALOG_CAL && wstrb[0]
                    && !ctrl[`RPD_B_CAL_LOCK]) begin
                    next_cal = wdata[7:0];
                end
                if (!ctrl[`RPD_B_CAL_LOCK] && next_ctrl[`RPD_B_CAL_LOCK]) begin
                    next_load_cnt = LOAD_CYCLES[19:0];
                    next_busy     = 1'b1;
                end else if (!next_ctrl[`RPD_B_CAL_LOCK]) begin
                    next_load_cnt = 20'h00000;
                    next_busy     = 1'b0;
                end else if (load_cnt != 20'h00000) begin
                    next_load_cnt = load_cnt - 20'h00001;
                    next_busy     = (load_cnt != 20'h00001);
                end
                if (ctrl[`RPD_B_CAL_LOCK] && !cal_busy) begin
                    next_cal = otp_q2;
                end
            end
            default: next_state = rpd_pkg::RPD_SETTLE0;
        endcase
    end

    always_ff @(posedge aclk) begin
        bat_q1             <= battery_retained;
        bat_q2             <= bat_q1;
        otp_q1             <= otp_cal_value;
        otp_q2             <= otp_q1;
        ctrl               <= next_ctrl;
        analog_calibration <= next_cal;
        if (!aresetn) begin
            state         <= rpd_pkg::RPD_SETTLE0;
            load_cnt      <= 20'h00000;
            cal_busy      <= 1'b0;
            retained_seen <= 1'b0;
        end else begin
            state         <= next_state;
            load_cnt      <= next_load_cnt;
            cal_busy      <= next_busy;
            retained_seen <= next_retained_seen;
        end
    end

    assign halt_update            = ctrl[`RPD_B_HALT];
    assign osc_fail_flag          = ctrl[`RPD_B_OSC_FAIL];
    assign timer_enable           = ctrl[`RPD_B_TIMER_EN];
    assign timer_irq_pulse_select = ctrl[`RPD_B_TIMER_PULSE];
    assign timer_irq_enable       = ctrl[`RPD_B_TIMER_IRQ_EN];
    assign timer_clk_div_hi       = ctrl[`RPD_B_TIMER_DIV_HI];
    assign timer_clk_div_lo       = ctrl[`RPD_B_TIMER_DIV_LO];
    assign sqw_rate_bit0          = ctrl[`RPD_B_SQW_RATE0];
    assign sqw_rate_upper_bits    = ctrl[`RPD_B_SQW_UP_LSB +: 3];
    assign alarm1_repeat_bits     = ctrl[`RPD_B_ALM1_RPT_LSB +: 5];
    assign alarm2_repeat_bits     = ctrl[`RPD_B_ALM2_RPT_LSB +: 5];
    assign alarm2_enable          = ctrl[`RPD_B_ALM2_EN];
    assign cal_lock               = ctrl[`RPD_B_CAL_LOCK];

    // Bus slave; address and data latched separately, write done once both held
    always_comb begin
        next_aw_full = aw_full;
        next_w_full  = w_full;
        next_aw_idx  = aw_idx;
        next_wdata   = wdata;
        next_wstrb   = wstrb;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_rvalid  = s_axi_rvalid;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_full = 1'b1;
            next_aw_idx  = s_axi_awaddr[7:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_full = 1'b1;
            next_wdata  = s_axi_wdata;
            next_wstrb  = s_axi_wstrb;
        end
        if (wr_fire) begin
            next_aw_full = 1'b0;
            next_w_full  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = idx_mapped(aw_idx) ? `RPD_RESP_OKAY : `RPD_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rdata  = reg_read(s_axi_araddr[7:2]);
            next_rresp  = idx_mapped(s_axi_araddr[7:2]) ? `RPD_RESP_OKAY : `RPD_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        next_awready = (next_state == rpd_pkg::RPD_RUN) && !next_aw_full && !next_bvalid;
        next_wready  = (next_state == rpd_pkg::RPD_RUN) && !next_w_full && !next_bvalid;
        next_arready = (next_state == rpd_pkg::RPD_RUN) && !next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full       <= 1'b0;
            w_full        <= 1'b0;
            aw_idx        <= 6'h00;
            wdata         <= 32'h00000000;
            wstrb         <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= 2'h0;
        end else begin
            aw_full       <= next_aw_full;
            w_full        <= next_w_full;
            aw_idx        <= next_aw_idx;
            wdata         <= next_wdata;
            wstrb         <= next_wstrb;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence init_fresh_s;
        state == rpd_pkg::RPD_INIT && !bat_q2;
    endsequence

    sequence init_kept_s;
        state == rpd_pkg::RPD_INIT && bat_q2;
    endsequence

    AST_FRESH_DEFAULTS: assert property (init_fresh_s |=> ctrl == `RPD_CTRL_INIT)
        else $error("first power-up defaults wrong");

    AST_RETAINED_FORCE: assert property (init_kept_s |=> halt_update && !timer_enable
        && ctrl[22:3] == $past(ctrl[22:3]) && osc_fail_flag == $past(osc_fail_flag))
        else $error("retained power-up bits wrong");

    AST_LOCKED_COPY: assert property (state == rpd_pkg::RPD_RUN && cal_lock && !cal_busy
        |=> analog_calibration == $past(otp_q2))
        else $error("locked calibration not factory value");

    AST_UNLOCKED_WRITE: assert property (state == rpd_pkg::RPD_RUN && wr_fire
        && aw_idx == `RPD_IDX_ANALOG_CAL && wstrb[0] && !cal_lock
        |=> analog_calibration == $past(wdata[7:0]))
        else $error("unlocked calibration write lost");

    AST_LOAD_HOLD: assert property (cal_busy && cal_lock && load_cnt > 20'h00001
        |=> (cal_busy || !cal_lock) && $stable(analog_calibration))
        else $error("calibration changed before load time");

endmodule : rpd_loader

// *** bench/rpd_host_model.sv ***
// Register-bus host model driving the loader's AXI4-Lite slave port
`timescale 1ns/1ps
module rpd_host_model (
    input  wire logic        aclk,
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'h0;
    end

    // Leading edge keeps two back-to-back calls from driving one signal twice
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        logic aw_p;
        logic w_p;
        aw_p = 1'b1;
        w_p = 1'b1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_bvalid && !aw_p && !w_p) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
            if (aw_p && s_axi_awready) begin
                aw_p = 1'b0;
                s_axi_awvalid <= 1'b0;
                // Released payload inverted so stale values cannot pass
                s_axi_awaddr <= ~a;
            end
            if (w_p && s_axi_wready) begin
                w_p = 1'b0;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_p;
        ar_p = 1'b1;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_rvalid && !ar_p) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
            if (ar_p && s_axi_arready) begin
                ar_p = 1'b0;
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
        end
    endtask : rd
endmodule : rpd_host_model

// *** bench/tb_top.sv ***
// Self-checking bench for the power-up defaults and calibration loader
`timescale 1ns/1ps
`include "rpd_regs.svh"
module tb_top;
    localparam int LOAD = 20;
    localparam logic [7:0] A_CAL = {`RPD_IDX_ANALOG_CAL, 2'b00};
    localparam logic [7:0] A_CTRL = {`RPD_IDX_CTRL, 2'b00};
    localparam logic [7:0] A_STAT = {`RPD_IDX_STATUS, 2'b00};
    logic        aclk = 1'b0, aresetn = 1'b0, battery_retained = 1'b0;
    logic [7:0]  otp_cal_value = 8'h00, s_axi_awaddr, s_axi_araddr, analog_calibration;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        halt_update, osc_fail_flag, timer_enable, timer_irq_pulse_select;
    logic        timer_irq_enable, timer_clk_div_hi, timer_clk_div_lo, sqw_rate_bit0;
    logic        alarm2_enable, cal_lock, cal_busy;
    logic [2:0]  sqw_rate_upper_bits;
    logic [4:0]  alarm1_repeat_bits, alarm2_repeat_bits;
    logic [22:0] ctrl_pins, pat;
    logic [7:0]  cv;
    int          bad_count = 0, compares = 0, seed, n;

    assign ctrl_pins = {alarm2_enable, alarm2_repeat_bits, alarm1_repeat_bits, cal_lock,
        sqw_rate_upper_bits, sqw_rate_bit0, timer_clk_div_hi, timer_clk_div_lo,
        timer_irq_enable, timer_irq_pulse_select, timer_enable, osc_fail_flag, halt_update};

    always #12.5 aclk = ~aclk;

    rpd_loader #(.LOAD_CYCLES(LOAD)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .battery_retained(battery_retained),
        .otp_cal_value(otp_cal_value), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .halt_update(halt_update), .osc_fail_flag(osc_fail_flag),
        .timer_enable(timer_enable), .timer_irq_pulse_select(timer_irq_pulse_select),
        .timer_irq_enable(timer_irq_enable), .timer_clk_div_hi(timer_clk_div_hi),
        .timer_clk_div_lo(timer_clk_div_lo), .sqw_rate_bit0(sqw_rate_bit0),
        .sqw_rate_upper_bits(sqw_rate_upper_bits),
        .alarm1_repeat_bits(alarm1_repeat_bits),
        .alarm2_repeat_bits(alarm2_repeat_bits), .alarm2_enable(alarm2_enable),
        .cal_lock(cal_lock), .analog_calibration(analog_calibration),
        .cal_busy(cal_busy)
    );
    rpd_host_model i_host (
        .aclk(aclk), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready)
    );

    function automatic logic [31:0] exp_kept(input logic [22:0] p);
        return {9'h0, (p | 23'h000001) & ~23'h000004};
    endfunction : exp_kept

    task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_val

    task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
        chk_val(nm, {30'h0, e}, {30'h0, g});
    endtask : chk_resp

    task automatic report_and_stop;
        if (bad_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop

    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (5) @(posedge aclk);
    endtask : do_reset

    initial begin
        repeat (3000) @(posedge aclk);
        bad_count++;
        report_and_stop;
    end

    initial begin
        seed = 90764;
        @(posedge aclk);
        otp_cal_value <= 8'($random(seed));
        do_reset;
        chk_val("init pins", {9'h0, `RPD_CTRL_INIT}, {9'h0, ctrl_pins});
        i_host.rd(A_CTRL, rv, rr);
        chk_val("init ctrl", {9'h0, `RPD_CTRL_INIT}, rv);
        i_host.rd(A_CAL, rv, rr);
        chk_val("init cal", 32'h0, rv);
        for (int i = 0; i < 3; i++) begin
            cv = (i == 0) ? 8'hFF : 8'($random(seed));
            i_host.wr(A_CAL, {24'h0, cv}, 4'hF, rr);
            i_host.rd(A_CAL, rv, rr);
            chk_val("cal rw", {24'h0, cv}, rv);
            chk_val("cal pin", {24'h0, cv}, {24'h0, analog_calibration});
            pat = 23'($random(seed)) & ~23'h000800;
            i_host.wr(A_CTRL, {9'h0, pat}, 4'hF, rr);
            i_host.rd(A_CTRL, rv, rr);
            chk_val("ctrl rw", {9'h0, pat}, rv);
        end
        // Byte lanes: calibration ignores a write without lane 0
        i_host.wr(A_CAL, {24'h0, ~cv}, 4'hE, rr);
        i_host.rd(A_CAL, rv, rr);
        chk_val("cal strobe", {24'h0, cv}, rv);
        i_host.wr(A_CTRL, {9'h0, ~pat}, 4'h4, rr);
        pat = {~pat[22:16], pat[15:0]};
        i_host.rd(A_CTRL, rv, rr);
        chk_val("ctrl strobe", {9'h0, pat}, rv);
        // Held value differs from the factory one so the load is visible
        cv = ~otp_cal_value;
        i_host.wr(A_CAL, {24'h0, cv}, 4'hF, rr);
        i_host.wr(8'hFC, 32'h0, 4'hF, rr);
        chk_resp("unmapped wr", `RPD_RESP_SLVERR, rr);
        i_host.rd(8'hFC, rv, rr);
        chk_resp("unmapped rd", `RPD_RESP_SLVERR, rr);
        i_host.wr(A_CTRL, {9'h0, pat | 23'h000800}, 4'hF, rr);
        chk_val("busy", 32'h1, {31'h0, cal_busy});
        i_host.rd(A_STAT, rv, rr);
        chk_val("status busy", 32'h1, rv);
        n = 0;
        // Host waits out the load; sampled mid-cycle where outputs are settled
        while (cal_busy === 1'b1 && n < LOAD + 10) begin
            if (analog_calibration !== cv) n = 1000;
            @(negedge aclk);
            n++;
        end
        chk_val("cal held in load", {24'h0, cv}, {24'h0, analog_calibration});
        chk_val("load ends", 32'h1, {31'h0, n <= LOAD + 3 && n >= LOAD - 6});
        repeat (3) @(posedge aclk);
        chk_val("cal loaded", {24'h0, otp_cal_value}, {24'h0, analog_calibration});
        i_host.wr(A_CAL, {24'h0, ~otp_cal_value}, 4'hF, rr);
        chk_resp("locked wr", `RPD_RESP_OKAY, rr);
        i_host.rd(A_CAL, rv, rr);
        chk_val("cal ro", {24'h0, otp_cal_value}, rv);
        pat = (23'($random(seed)) & ~23'h000801) | 23'h000004;
        i_host.wr(A_CTRL, {9'h0, pat}, 4'hF, rr);
        battery_retained <= 1'b1;
        do_reset;
        chk_val("kept pins", exp_kept(pat), {9'h0, ctrl_pins});
        chk_val("kept cal", {24'h0, otp_cal_value}, {24'h0, analog_calibration});
        i_host.rd(A_STAT, rv, rr);
        chk_val("status kept", 32'h2, rv);
        report_and_stop;
    end
endmodule : tb_top
